/* logic/rss_sampler.sv */
// strap capture, configuration registers and led drive
`default_nettype none

module rss_sampler #(
    parameter int BLINK_CYCLES = rss_pkg::BLINK_CYCLES,
    parameter int ACT_CYCLES   = rss_pkg::ACT_CYCLES
) (
    // clock and reset
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // axi4-lite write address
    input  wire logic [7:0]                 awaddr,
    input  wire logic                       awvalid,
    output logic                            awready,
    // axi4-lite write data
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output logic                            wready,
    // axi4-lite write response
    output logic [1:0]                      bresp,
    output logic                            bvalid,
    input  wire logic                       bready,
    // axi4-lite read address
    input  wire logic [7:0]                 araddr,
    input  wire logic                       arvalid,
    output logic                            arready,
    // axi4-lite read data
    output logic [31:0]                     rdata,
    output logic [1:0]                      rresp,
    output logic                            rvalid,
    input  wire logic                       rready,
    // shared strap pins
    input  wire logic [rss_pkg::STRAP_W-1:0] strap_pin_in,
    output logic [rss_pkg::STRAP_W-1:0]      strap_pin_out,
    output logic [rss_pkg::STRAP_W-1:0]      strap_pin_oe,
    // functional sources of the shared pins
    input  wire logic [3:0]                 rx_data_in,
    input  wire logic                       collision_in,
    input  wire logic                       carrier_sense_in,
    input  wire logic                       rx_error_in,
    // line status for the leds
    input  wire logic                       link_up,
    input  wire logic                       speed_100,
    input  wire logic                       activity,
    input  wire logic                       full_duplex,
    // configuration outputs
    output logic [4:0]                      mgmt_addr,
    output logic                            neg_enable,
    output logic                            force_speed_100,
    output logic                            force_full_duplex,
    output logic [3:0]                      advert_caps,
    output logic                            auto_crossover_enable_strap,
    output logic                            mdix_force,
    output var rss_pkg::rss_led_mode_t      led_mode
);

    localparam logic [rss_pkg::CNT_W-1:0] BLINK_LAST =
        rss_pkg::CNT_W'(BLINK_CYCLES - 1);
    localparam logic [rss_pkg::CNT_W-1:0] ACT_LOAD =
        rss_pkg::CNT_W'(ACT_CYCLES);

    logic [rss_pkg::STRAP_W-1:0] strap_sync;
    rss_pkg::rss_strap_t         now_strap;
    rss_pkg::rss_strap_t         cap_reg;

    logic [15:0] bmcr_reg;
    logic [15:0] adv_reg;
    logic [15:0] phycr_reg;
    logic [15:0] led_control_reg_reg;

    logic       aw_got;
    logic       w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       wr_fire;
    logic [7:0] wr_word;
    logic [7:0] rd_word;
    logic [31:0] rd_mux;

    logic [rss_pkg::CNT_W-1:0] blink_cnt;
    logic                      blink_phase;
    logic [rss_pkg::CNT_W-1:0] act_cnt;
    logic                      act_on;
    logic                      link_v;
    logic                      act_v;
    logic [2:0]                led_v;
    logic [rss_pkg::STRAP_W-1:0] func_v;

    // pin sampling
    rss_sync #(
        .W(rss_pkg::STRAP_W)
    ) u_sync (
        .clk(aclk),
        .d  (strap_pin_in),
        .q  (strap_sync)
    );

    assign now_strap = rss_pkg::rss_strap_t'(strap_sync);

    // capture runs only while reset is held, then holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_reg <= now_strap;
        end
    end

    // undriven pins resolve through the pad pulls
    assign mgmt_addr = cap_reg.addr;

    // basic mode control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bmcr_reg                       <= rss_pkg::REG_RESET;
            bmcr_reg[rss_pkg::BMCR_NEG]    <= now_strap.neg_en;
            bmcr_reg[rss_pkg::BMCR_SPEED]  <= now_strap.cap_hi;
            bmcr_reg[rss_pkg::BMCR_DUPLEX] <= now_strap.cap_lo;
        end else if (wr_fire && wr_word == rss_pkg::OFS_BMCR) begin
            bmcr_reg <= rss_pkg::wmerge(bmcr_reg, w_data, w_strb, rss_pkg::BMCR_WMASK);
        end
    end

    // negotiation advertisement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adv_reg <= rss_pkg::REG_RESET;
            adv_reg[rss_pkg::ADV_MSB:rss_pkg::ADV_LSB] <= rss_pkg::adv_caps(now_strap);
        end else if (wr_fire && wr_word == rss_pkg::OFS_ADV) begin
            adv_reg <= rss_pkg::wmerge(adv_reg, w_data, w_strb, rss_pkg::ADV_WMASK);
        end
    end

    // crossover control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phycr_reg                      <= rss_pkg::REG_RESET;
            phycr_reg[rss_pkg::PHYCR_AUTO] <= now_strap.crossover_enable_strap;
        end else if (wr_fire && wr_word == rss_pkg::OFS_PHYCR) begin
            phycr_reg <= rss_pkg::wmerge(phycr_reg, w_data, w_strb, rss_pkg::PHYCR_WMASK);
        end
    end

    // led control
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_control_reg_reg                      <= rss_pkg::REG_RESET;
            led_control_reg_reg[rss_pkg::LED_SEL_LO] <= now_strap.led_mode_strap;
        end else if (wr_fire && wr_word == rss_pkg::OFS_LED_CONTROL_REG) begin
            led_control_reg_reg <= rss_pkg::wmerge(led_control_reg_reg, w_data, w_strb, rss_pkg::LED_CONTROL_REG_WMASK);
        end
    end

    assign neg_enable        = bmcr_reg[rss_pkg::BMCR_NEG];
    assign force_speed_100   = bmcr_reg[rss_pkg::BMCR_SPEED];
    assign force_full_duplex = bmcr_reg[rss_pkg::BMCR_DUPLEX];
    assign advert_caps       = adv_reg[rss_pkg::ADV_MSB:rss_pkg::ADV_LSB];
    assign auto_crossover_enable_strap      = phycr_reg[rss_pkg::PHYCR_AUTO];
    assign mdix_force        = phycr_reg[rss_pkg::PHYCR_FORCE];

    // led mode selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_mode <= rss_pkg::LED_MODE1;
        end else if (led_control_reg_reg[rss_pkg::LED_SEL_LO]) begin
            led_mode <= rss_pkg::LED_MODE1;
        end else if (led_control_reg_reg[rss_pkg::LED_SEL_HI]) begin
            led_mode <= rss_pkg::LED_MODE3;
        end else begin
            led_mode <= rss_pkg::LED_MODE2;
        end
    end

    // blink half-period divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
        end else if (blink_cnt == BLINK_LAST) begin
            blink_cnt   <= '0;
            blink_phase <= ~blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    // activity pulse stretch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_cnt <= '0;
        end else if (activity) begin
            act_cnt <= ACT_LOAD;
        end else if (act_cnt != '0) begin
            act_cnt <= act_cnt - 1'b1;
        end
    end

    assign act_on = (act_cnt != '0);

    always_comb begin
        link_v = link_up;
        act_v  = 1'b0;
        unique case (led_mode)
            rss_pkg::LED_MODE1: begin
                act_v = act_on;
            end
            rss_pkg::LED_MODE2: begin
                link_v = link_up & ~(act_on & blink_phase);
            end
            rss_pkg::LED_MODE3: begin
                link_v = link_up & ~(act_on & blink_phase);
                act_v  = full_duplex;
            end
            default: begin
                act_v = 1'b0;
            end
        endcase
    end

    // polarity: bit0 link, bit1 rate, bit2 activity
    assign led_v = {act_v, speed_100, link_v} ^ led_control_reg_reg[rss_pkg::LED_POL_MSB:0];

    // functional values in strap pin order
    assign func_v = {rx_data_in, collision_in, led_v[2], led_v[1], led_v[0],
                     carrier_sense_in, rx_error_in};

    rss_pin #(
        .W(rss_pkg::STRAP_W)
    ) u_pin (
        .clk    (aclk),
        .rst_n  (aresetn),
        .func   (func_v),
        .pin_out(strap_pin_out),
        .pin_oe (strap_pin_oe)
    );

    // write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_got  <= 1'b0;
            aw_addr <= 8'h00;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got  <= 1'b1;
            aw_addr <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
            aw_got  <= 1'b0;
        end else if (!aw_got) begin
            awready <= 1'b1;
        end
    end

    // write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_got  <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (wvalid && wready) begin
            wready <= 1'b0;
            w_got  <= 1'b1;
            w_data <= wdata;
            w_strb <= wstrb;
        end else if (bvalid && bready) begin
            wready <= 1'b1;
            w_got  <= 1'b0;
        end else if (!w_got) begin
            wready <= 1'b1;
        end
    end

    assign wr_fire = aw_got && w_got && !bvalid;
    assign wr_word = {aw_addr[7:2], 2'h0};

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= rss_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= rss_pkg::mapped(aw_addr) ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // read mux
    assign rd_word = {araddr[7:2], 2'h0};

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (rd_word)
            rss_pkg::OFS_BMCR:  rd_mux = {16'h0000, bmcr_reg};
            rss_pkg::OFS_ADV:   rd_mux = {16'h0000, adv_reg};
            rss_pkg::OFS_PHYCR: rd_mux = {16'h0000, phycr_reg};
            rss_pkg::OFS_LED_CONTROL_REG: rd_mux = {16'h0000, led_control_reg_reg};
            rss_pkg::OFS_STRAP: rd_mux = {20'h00000, led_mode, cap_reg};
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= rss_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rss_pkg::mapped(araddr) ? rss_pkg::RESP_OKAY : rss_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

endmodule : rss_sampler

`default_nettype wire

/* logic/rss_pkg.sv */
// shared constants, types and helpers of the reset strap sampler
// Notes on behaviour
// - sample every strap pin during hardware reset
// - latch five address straps, values 0-31
// - undriven address straps read zero, address 0
// - negotiate high: negotiate, advertise selected set
// - negotiate low: force selected speed, duplex
// - capability codes map to speed/duplex sets
// - reset loads straps into control, advert regs
// - undriven negotiation straps read ones, all advertised
// - led strap plus register bit pick led mode
// - crossover strap low disables automatic crossover
// - after release pins return to functional roles
// - straps set advert bits 8:5, offset 0x04
// - led bit5 one: mode1; else bit6 picks 3/2
`default_nettype none

package rss_pkg;

    localparam int STRAP_W = 10;

    // pin order: addr[4:0], negotiate, cap hi, cap lo, led, crossover
    typedef struct packed {
        logic [4:0] addr;
        logic       neg_en;
        logic       cap_hi;
        logic       cap_lo;
        logic       led_mode_strap;
        logic       crossover_enable_strap;
    } rss_strap_t;

    typedef enum logic [1:0] {
        LED_MODE1,
        LED_MODE2,
        LED_MODE3
    } rss_led_mode_t;

    // register offsets (byte addresses)
    localparam logic [7:0] OFS_BMCR  = 8'h00;
    localparam logic [7:0] OFS_ADV   = 8'h04;
    localparam logic [7:0] OFS_PHYCR = 8'h10;
    localparam logic [7:0] OFS_LED_CONTROL_REG = 8'h18;
    localparam logic [7:0] OFS_STRAP = 8'h1C;

    // field positions
    localparam int BMCR_SPEED  = 13;
    localparam int BMCR_NEG    = 12;
    localparam int BMCR_DUPLEX = 8;
    localparam int ADV_LSB     = 5;
    localparam int ADV_MSB     = 8;
    localparam int PHYCR_AUTO  = 6;
    localparam int PHYCR_FORCE = 5;
    localparam int LED_SEL_HI  = 6;
    localparam int LED_SEL_LO  = 5;
    localparam int LED_POL_MSB = 2;

    // writable bits and reset values
    localparam logic [15:0] BMCR_WMASK  = 16'h3100;
    localparam logic [15:0] ADV_WMASK   = 16'h01E0;
    localparam logic [15:0] PHYCR_WMASK = 16'h0060;
    localparam logic [15:0] LED_CONTROL_REG_WMASK = 16'h0067;
    localparam logic [15:0] REG_RESET   = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing
    localparam int CLK_MHZ       = 100;
    localparam int BLINK_HALF_MS = 100;
    localparam int ACT_PULSE_MS  = 200;
    localparam int BLINK_CYCLES  = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam int ACT_CYCLES    = ACT_PULSE_MS * CLK_MHZ * 1000;
    localparam int CNT_W         = 25;

    // caps bit3..0: 100 full, 100 half, 10 full, 10 half
    function automatic logic [3:0] adv_caps(input rss_strap_t s);
        logic [1:0] code;
        code = {s.cap_hi, s.cap_lo};
        if (!s.neg_en) begin
            return 4'h1 << code;
        end
        unique case (code)
            2'h0:    return 4'h3;
            2'h1:    return 4'h3;
            2'h2:    return 4'h5;
            default: return 4'hF;
        endcase
    endfunction : adv_caps

    function automatic logic [15:0] wmerge(input logic [15:0] cur, input logic [31:0] d,
                                           input logic [3:0] s, input logic [15:0] m);
        logic [15:0] be;
        be = {{8{s[1]}}, {8{s[0]}}} & m;
        return (cur & ~be) | (d[15:0] & be);
    endfunction : wmerge

    function automatic logic mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        return (w == OFS_BMCR) || (w == OFS_ADV) || (w == OFS_PHYCR)
            || (w == OFS_LED_CONTROL_REG) || (w == OFS_STRAP);
    endfunction : mapped

endpackage : rss_pkg

`default_nettype wire

/* logic/rss_sync.sv */
// three-stage pin synchroniser with agreement filter
`default_nettype none

module rss_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk,
    // pins and filtered value
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    // not reset: must keep sampling while reset is held
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            s1[i] <= d[i];
            s2[i] <= s1[i];
            s3[i] <= s2[i];
        end

        always_ff @(posedge clk) begin
            if (s2[i] == s3[i]) begin
                q[i] <= s3[i];
            end
        end
    end

endmodule : rss_sync

`default_nettype wire

/* logic/rss_pin.sv */
// registered output stage of the shared strap pins
`default_nettype none

module rss_pin #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // functional values
    input  wire logic [W-1:0] func,
    // pin drive
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe
);

    // released while reset is held so the straps can be sampled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_oe  <= '0;
            pin_out <= '0;
        end else begin
            pin_oe  <= '1;
            pin_out <= func;
        end
    end

endmodule : rss_pin

`default_nettype wire

/* tb/rss_strap_board.sv */
// board strap resistors and weak pulls on the shared pins
`default_nettype none

module rss_strap_board (
    // device pin drive
    input  wire logic [9:0] pin_out,
    input  wire logic [9:0] pin_oe,
    // fitted resistors and their levels
    input  wire logic [9:0] ext_fit,
    input  wire logic [9:0] ext_lvl,
    // resolved level
    output logic      [9:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 1ps;

    // weak pulls: address pins low, the other five high
    localparam logic [9:0] PULLS = 10'h01F;

    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (ext_fit[i]) pin_lvl[i] = ext_lvl[i];
            else pin_lvl[i] = PULLS[i];
        end
    end
endmodule : rss_strap_board

`default_nettype wire

/* tb/rss_sampler_asserts.sv */
// port checker of the strap sampler
`default_nettype none

module rss_sampler_asserts (
    // clock and reset
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // read channels
    input wire logic                        arvalid,
    input wire logic                        arready,
    input wire logic                        rvalid,
    input wire logic                        rready,
    // shared pins
    input wire logic [rss_pkg::STRAP_W-1:0] strap_pin_in,
    input wire logic [rss_pkg::STRAP_W-1:0] strap_pin_out,
    input wire logic [rss_pkg::STRAP_W-1:0] strap_pin_oe,
    input wire logic [3:0]                  rx_data_in,
    input wire logic                        collision_in,
    input wire logic                        carrier_sense_in,
    input wire logic                        rx_error_in,
    // configuration
    input wire logic [4:0]                  mgmt_addr,
    input wire logic                        neg_enable,
    input wire logic                        force_speed_100,
    input wire logic                        force_full_duplex,
    input wire logic [3:0]                  advert_caps,
    input wire logic                        auto_crossover_enable_strap,
    input var  rss_pkg::rss_led_mode_t      led_mode
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    function automatic logic [3:0] caps(input logic [2:0] s);
        if (!s[2]) return 4'h1 << s[1:0];
        return (s[1:0] == 2'h3) ? 4'hF : (s[1:0] == 2'h2) ? 4'h5 : 4'h3;
    endfunction : caps

    chk_oe_release: assert property ($rose(aresetn) |-> !(|strap_pin_oe) ##1 &strap_pin_oe)
        else $error("pins not handed back after reset");
    chk_addr_capture: assert property ($rose(aresetn) |-> mgmt_addr == strap_pin_in[9:5])
        else $error("address not captured");
    chk_cfg_capture: assert property ($rose(aresetn) |-> auto_crossover_enable_strap == strap_pin_in[0]
        && {neg_enable, force_speed_100, force_full_duplex} == strap_pin_in[4:2])
        else $error("control straps not loaded");
    chk_advert_caps: assert property ($rose(aresetn) |-> advert_caps == caps(strap_pin_in[4:2]))
        else $error("advertised set wrong");
    chk_led_default: assert property ($rose(aresetn) |=>
        led_mode == ($past(strap_pin_in[1]) ? rss_pkg::LED_MODE1 : rss_pkg::LED_MODE2))
        else $error("led mode after reset wrong");
    chk_addr_hold: assert property ($past(aresetn) |-> $stable(mgmt_addr))
        else $error("captured address moved");
    chk_func_pins: assert property ($past(aresetn) |-> {strap_pin_out[9:5], strap_pin_out[1:0]}
        == $past({rx_data_in, collision_in, carrier_sense_in, rx_error_in}))
        else $error("functional pin value wrong");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_read_drop: assert property (rvalid && rready |=> !rvalid)
        else $error("read answer repeated");

    cov_forced: cover property ($rose(aresetn) && !neg_enable);
    cov_addr_top: cover property ($rose(aresetn) && mgmt_addr == 5'h1F);
    cov_read: cover property (rvalid && rready);
endmodule : rss_sampler_asserts

bind rss_sampler rss_sampler_asserts rss_sampler_asserts_inst (.aclk, .aresetn, .arvalid, .arready, .rvalid,
    .rready, .strap_pin_in, .strap_pin_out, .strap_pin_oe, .rx_data_in, .collision_in, .carrier_sense_in,
    .rx_error_in, .mgmt_addr, .neg_enable, .force_speed_100, .force_full_duplex, .advert_caps, .auto_crossover_enable_strap,
    .led_mode);

`default_nettype wire

/* tb/rss_sampler_tb.sv */
// self-checking bench of the strap sampler
`default_nettype none

module rss_sampler_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, collision_in, carrier_sense_in, rx_error_in;
    logic        link_up, speed_100, activity, full_duplex, awready, wready, bvalid, arready, rvalid;
    logic        auto_crossover_enable_strap, mdix_force;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'h0, rx_data_in, advert_caps;
    logic [1:0]  bresp, rresp;
    logic [9:0]  strap_pin_in, strap_pin_out, strap_pin_oe, ext_fit = 10'h000, ext_lvl = 10'h000, strap_exp;
    logic [4:0]  mgmt_addr;
    rss_pkg::rss_led_mode_t led_mode;
    int          err_total = 0, n_compared = 0, mdl[int];
    int          msk[int] = '{0: rss_pkg::BMCR_WMASK, 4: rss_pkg::ADV_WMASK, 16: rss_pkg::PHYCR_WMASK,
                             24: rss_pkg::LED_CONTROL_REG_WMASK};

    rss_sampler #(.BLINK_CYCLES(4), .ACT_CYCLES(8)) rss_sampler_inst (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .strap_pin_in, .strap_pin_out, .strap_pin_oe, .rx_data_in,
        .collision_in, .carrier_sense_in, .rx_error_in, .link_up, .speed_100, .activity, .full_duplex,
        .mgmt_addr, .neg_enable(), .force_speed_100(), .force_full_duplex(), .advert_caps, .auto_crossover_enable_strap,
        .mdix_force, .led_mode);
    rss_strap_board rss_strap_board_inst (.pin_out(strap_pin_out), .pin_oe(strap_pin_oe), .ext_fit,
        .ext_lvl, .pin_lvl(strap_pin_in));

    always #5 aclk = ~aclk;

    initial {rx_data_in, collision_in, carrier_sense_in, rx_error_in, link_up, speed_100, activity,
             full_duplex} = 11'h000;
    always @(posedge aclk) begin
        {rx_data_in, collision_in, carrier_sense_in, rx_error_in} <= 7'($urandom);
        {link_up, speed_100, activity, full_duplex} <= 4'($urandom);
    end

    function automatic int caps_of(input int c);
        return c < 4 ? 1 << c : c < 6 ? 3 : c == 6 ? 5 : 15;
    endfunction : caps_of

    function automatic int mode_of(input int l);
        return l[5] ? 0 : l[6] ? 2 : 1;
    endfunction : mode_of

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp

    task automatic end_of_test();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    // entered just after a rising edge; ready sampled and payload released at the taking edge
    task automatic axi(input bit wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                       output logic [31:0] q, output logic [1:0] r);
        bit dn;
        dn = 1'b0;
        if (wr) begin
            {awaddr, wdata, wstrb} <= {a, d, st};
            {awvalid, wvalid, bready} <= 3'h7;
        end else begin
            araddr <= a;
            {arvalid, rready} <= 2'h3;
        end
        while (!dn) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (arvalid && arready) arvalid <= 1'b0;
            dn = wr ? bvalid : rvalid;
            q = rdata;
            r = wr ? bresp : rresp;
        end
        {bready, rready} <= 2'h0;
        @(posedge aclk);
    endtask : axi

    task automatic rd(input int a);
        logic [31:0] q;
        logic [1:0]  r;
        axi(1'b0, 8'(a), 32'h0, 4'h0, q, r);
        cmp("rdata", mdl.exists(a) ? mdl[a] : 0, q);
        cmp("rresp", mdl.exists(a) ? 0 : 2, r);
    endtask : rd

    // led pins lag their line inputs by one edge; link checked in mode 1 only
    task automatic leds();
        logic s, k;
        int   p;
        p = mdl[24];
        @(posedge aclk);
        {s, k} = {speed_100, link_up};
        @(posedge aclk);
        cmp("rate_led", s ^ p[1], strap_pin_out[3]);
        if (mode_of(p) == 0) cmp("link_led", k ^ p[0], strap_pin_out[2]);
    endtask : leds

    task automatic wr(input int a, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] q;
        logic [1:0]  r;
        int          m;
        axi(1'b1, 8'(a), d, st, q, r);
        cmp("bresp", mdl.exists(a) ? 0 : 2, r);
        if (msk.exists(a)) begin
            m = msk[a] & {16'h0, {8{st[1]}}, {8{st[0]}}};
            mdl[a] = (mdl[a] & ~m) | (d & m);
            mdl[28] = (mode_of(mdl[24]) << 10) | strap_exp;
        end
    endtask : wr

    task automatic restart(input logic [9:0] fit, input logic [9:0] lvl);
        strap_exp = (fit & lvl) | (~fit & 10'h01F);
        mdl[0] = {strap_exp[3], strap_exp[4], 3'h0, strap_exp[2], 8'h00};
        mdl[4] = caps_of(strap_exp[4:2]) << 5;
        mdl[16] = {strap_exp[0], 6'h00};
        mdl[24] = {strap_exp[1], 5'h00};
        mdl[28] = (mode_of(mdl[24]) << 10) | strap_exp;
        {ext_fit, ext_lvl, aresetn} <= {fit, lvl, 1'b0};
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask : restart

    initial begin
        int a;
        void'($urandom(32'h83b4af02));
        for (int i = 0; i < 10; i++) begin
            a = (i == 1) ? 31 : $urandom_range(30);
            restart(i == 0 ? 10'h000 : 10'h3FF, {a[4:0], i[2:0], 2'($urandom)});
            cmp("addr", strap_exp[9:5], mgmt_addr);
            cmp("caps", caps_of(strap_exp[4:2]), advert_caps);
            cmp("mdix", strap_exp[0], auto_crossover_enable_strap);
            cmp("mode", mode_of(mdl[24]), led_mode);
            cmp("oe", 10'h3FF, strap_pin_oe);
            leds();
            wr(0, $urandom, 4'h3);
            wr(4, $urandom, 4'h3);
            foreach (mdl[k]) rd(k);
            rd(8);
        end
        for (int m = 0; m < 4; m++) begin
            wr(24, {m[1:0], 5'($urandom)}, 4'h1);
            cmp("mode", mode_of(mdl[24]), led_mode);
            leds();
        end
        wr(24, 32'h60, 4'h2);
        wr(16, 32'h20, 4'hF);
        cmp("mdix", 0, auto_crossover_enable_strap);
        cmp("force", 1, mdix_force);
        wr(28, 32'hFFFF, 4'hF);
        wr(8, 32'hFFFF, 4'hF);
        foreach (mdl[k]) rd(k);
        cmp("addr", strap_exp[9:5], mgmt_addr);
        end_of_test();
    end

    initial begin
        #100us;
        err_total++;
        end_of_test();
    end
endmodule : rss_sampler_tb

`default_nettype wire
